// ==== hw/ipi_top.sv ====
// Bus register port and interrupt flag logic
`timescale 1ns/10ps
module ipi_top (
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic addrSelectPin,
   input wire logic [ipi_pkg::FLAG_W-1:0] funcCond,
   input wire logic [ipi_pkg::SAMPLE_W-1:0] sampleData,
   output logic sampleReadStrobe,
   output logic irqOutA,
   output logic irqOutB
);
   logic sclS, sdaS, addrSelS;
   logic sclP_q, sclP_d, sdaP_q, sdaP_d;
   logic sclRise, sclFall, startSeen, stopSeen;
   ipi_pkg::ipi_state_e state_q, state_d;
   ipi_pkg::ipi_phase_e phase_q, phase_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] ptr_q, ptr_d;
   logic rw_q, rw_d, ack_q, ack_d;
   logic sdaOe_d, sdaOut_d;
   logic [7:0] enQ, en_d, mapQ, map_d, fmtQ, fmt_d;
   logic wrStrobe, loadTx, clrRead, sampleRd;
   logic sampleRd_d;
   logic [7:0] rdByte;
   logic [6:0] myAddr;
   logic [7:0] flagsQ, flags_d, setV;
   logic readPend_q, readPend_d;
   logic [7:0] actA, actB;

   ipi_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
      .clock(clock),
      .nrst(nrst),
      .ce(ce),
      .d({addrSelectPin, scl, sdaIn}),
      .q({addrSelS, sclS, sdaS})
   );

   assign sclRise = sclS & ~sclP_q;
   assign sclFall = ~sclS & sclP_q;
   assign startSeen = sclS & sclP_q & sdaP_q & ~sdaS;
   assign stopSeen = sclS & sclP_q & ~sdaP_q & sdaS;
   assign myAddr = addrSelS ? ipi_pkg::ADDR_PIN_HIGH : ipi_pkg::ADDR_PIN_LOW;

   // Register read mux, sample bytes low first
   always_comb begin
      rdByte = 8'h00;
      if (ptr_q >= ipi_pkg::REG_SAMPLE_LO && ptr_q <= ipi_pkg::REG_SAMPLE_HI) begin
         rdByte = sampleData[8*(ptr_q - ipi_pkg::REG_SAMPLE_LO) +: 8];
      end else begin
         case (ptr_q)
            ipi_pkg::REG_ENABLE: rdByte = enQ;
            ipi_pkg::REG_PINSEL: rdByte = mapQ;
            ipi_pkg::REG_FLAGS: rdByte = flagsQ;
            ipi_pkg::REG_FORMAT: rdByte = fmtQ;
            default: rdByte = 8'h00;
         endcase
      end
   end

   // Bus framing
   always_comb begin
      sclP_d = sclS;
      sdaP_d = sdaS;
      state_d = state_q;
      phase_d = phase_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      ptr_d = ptr_q;
      rw_d = rw_q;
      ack_d = ack_q;
      sdaOe_d = sdaOe;
      sdaOut_d = 1'b0;
      en_d = enQ;
      map_d = mapQ;
      fmt_d = fmtQ;
      wrStrobe = 1'b0;
      loadTx = 1'b0;
      clrRead = 1'b0;
      sampleRd = 1'b0;
      if (startSeen) begin
         state_d = ipi_pkg::ST_RX;
         phase_d = ipi_pkg::PH_ADDR;
         cnt_d = 4'h0;
         sdaOe_d = 1'b0;
      end else if (stopSeen) begin
         state_d = ipi_pkg::ST_IDLE;
         sdaOe_d = 1'b0;
      end else begin
         case (state_q)
            ipi_pkg::ST_RX: begin
               if (sclRise) begin
                  shift_d = {shift_q[6:0], sdaS};
                  cnt_d = 4'(cnt_q + 4'h1);
               end else if (sclFall && cnt_q == ipi_pkg::BYTE_BITS) begin
                  cnt_d = 4'h0;
                  state_d = ipi_pkg::ST_ACK;
                  sdaOe_d = 1'b1;
                  case (phase_q)
                     ipi_pkg::PH_ADDR: begin
                        if (shift_q[7:1] != myAddr) begin
                           state_d = ipi_pkg::ST_IDLE;
                           sdaOe_d = 1'b0;
                        end else begin
                           rw_d = shift_q[0];
                        end
                     end
                     ipi_pkg::PH_REG: ptr_d = shift_q;
                     default: begin
                        wrStrobe = 1'b1;
                        ptr_d = 8'(ptr_q + 8'h01);
                     end
                  endcase
               end
            end
            ipi_pkg::ST_ACK: begin
               if (sclFall) begin
                  sdaOe_d = 1'b0;
                  if (rw_q && phase_q == ipi_pkg::PH_ADDR) begin
                     loadTx = 1'b1;
                  end else begin
                     state_d = ipi_pkg::ST_RX;
                     phase_d = (phase_q == ipi_pkg::PH_ADDR) ? ipi_pkg::PH_REG
                                                            : ipi_pkg::PH_DATA;
                  end
               end
            end
            ipi_pkg::ST_TX: begin
               if (sclFall) begin
                  if (cnt_q == ipi_pkg::LAST_BIT) begin
                     sdaOe_d = 1'b0;
                     cnt_d = 4'h0;
                     state_d = ipi_pkg::ST_TXACK;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     cnt_d = 4'(cnt_q + 4'h1);
                     sdaOe_d = ~shift_q[6];
                  end
               end
            end
            ipi_pkg::ST_TXACK: begin
               if (sclRise) begin
                  ack_d = ~sdaS;
               end else if (sclFall) begin
                  if (ack_q) begin
                     loadTx = 1'b1;
                  end else begin
                     state_d = ipi_pkg::ST_IDLE;
                  end
               end
            end
            default: state_d = ipi_pkg::ST_IDLE;
         endcase
      end
      if (loadTx) begin
         shift_d = rdByte;
         ptr_d = 8'(ptr_q + 8'h01);
         sdaOe_d = ~rdByte[7];
         cnt_d = 4'h0;
         state_d = ipi_pkg::ST_TX;
         clrRead = (ptr_q == ipi_pkg::REG_FLAGS);
         sampleRd = (ptr_q >= ipi_pkg::REG_SAMPLE_LO && ptr_q <= ipi_pkg::REG_SAMPLE_HI);
      end
      if (wrStrobe) begin
         case (ptr_q)
            ipi_pkg::REG_ENABLE: en_d = shift_q;
            ipi_pkg::REG_PINSEL: map_d = shift_q;
            ipi_pkg::REG_FORMAT: fmt_d = shift_q;
            default: fmt_d = fmtQ;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         sclP_q <= 1'b1;
         sdaP_q <= 1'b1;
         state_q <= ipi_pkg::ST_IDLE;
         phase_q <= ipi_pkg::PH_ADDR;
         cnt_q <= 4'h0;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         ack_q <= 1'b0;
         sdaOe <= 1'b0;
         sdaOut <= 1'b0;
         enQ <= ipi_pkg::RST_ENABLE;
         mapQ <= ipi_pkg::RST_PINSEL;
         fmtQ <= ipi_pkg::RST_FORMAT;
      end else if (ce) begin
         sclP_q <= sclP_d;
         sdaP_q <= sdaP_d;
         state_q <= state_d;
         phase_q <= phase_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         ptr_q <= ptr_d;
         rw_q <= rw_d;
         ack_q <= ack_d;
         sdaOe <= sdaOe_d;
         sdaOut <= sdaOut_d;
         enQ <= en_d;
         mapQ <= map_d;
         fmtQ <= fmt_d;
      end
   end

   // Latched flags; hardware set wins over any clear
   always_comb begin
      setV = funcCond & enQ;
      flags_d = setV | (flagsQ & ~(clrRead ? ipi_pkg::OTHER_FLAGS : 8'h00));
      flags_d = flags_d & ~(readPend_q ? (ipi_pkg::DATA_FLAGS & ~funcCond) : 8'h00);
      readPend_d = sampleRd | (readPend_q & |(flags_d & ipi_pkg::DATA_FLAGS));
      sampleRd_d = sampleRd;
      actA = flagsQ & enQ & ~mapQ;
      actB = flagsQ & enQ & mapQ;
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         flagsQ <= ipi_pkg::RST_FLAGS;
         readPend_q <= 1'b0;
         sampleReadStrobe <= 1'b0;
      end else if (ce) begin
         flagsQ <= flags_d;
         readPend_q <= readPend_d;
         sampleReadStrobe <= sampleRd_d;
      end
   end

   ipi_irq_pin #(.FW(ipi_pkg::FLAG_W)) u_pinA (
      .clock(clock),
      .nrst(nrst),
      .ce(ce),
      .active(actA),
      .invert(fmtQ[ipi_pkg::FMT_INVERT_BIT]),
      .level(irqOutA)
   );

   ipi_irq_pin #(.FW(ipi_pkg::FLAG_W)) u_pinB (
      .clock(clock),
      .nrst(nrst),
      .ce(ce),
      .active(actB),
      .invert(fmtQ[ipi_pkg::FMT_INVERT_BIT]),
      .level(irqOutB)
   );

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   property p_ackAddr;
      ce && !startSeen && !stopSeen && state_q == ipi_pkg::ST_RX && sclFall &&
      cnt_q == ipi_pkg::BYTE_BITS && phase_q == ipi_pkg::PH_ADDR && shift_q[7:1] == myAddr
      |=> sdaOe && state_q == ipi_pkg::ST_ACK;
   endproperty
   a_ackAddr: assert property (p_ackAddr) else $error("address not acknowledged");

   property p_rxQuiet;
      state_q == ipi_pkg::ST_RX |-> !sdaOe;
   endproperty
   a_rxQuiet: assert property (p_rxQuiet) else $error("data line driven while listening");

   property p_txAckQuiet;
      state_q == ipi_pkg::ST_TXACK |-> !sdaOe;
   endproperty
   a_txAckQuiet: assert property (p_txAckQuiet) else $error("data line driven in master ack");

   property p_stopIdle;
      ce && stopSeen && !startSeen |=> state_q == ipi_pkg::ST_IDLE && !sdaOe;
   endproperty
   a_stopIdle: assert property (p_stopIdle) else $error("stop did not end transfer");

   property p_polarity;
      ce && fmtQ[ipi_pkg::FMT_INVERT_BIT] && actA == 8'h00 |=> irqOutA;
   endproperty
   a_polarity: assert property (p_polarity) else $error("inverted idle level wrong");

   property p_enableGate;
      ce && flagsQ == 8'h00 && (funcCond & enQ) == 8'h00 |=> flagsQ == 8'h00;
   endproperty
   a_enableGate: assert property (p_enableGate) else $error("disabled function raised a flag");

   property p_clearOnRead;
      ce && clrRead && (funcCond & enQ & ipi_pkg::OTHER_FLAGS) == 8'h00
      |=> (flagsQ & ipi_pkg::OTHER_FLAGS) == 8'h00;
   endproperty
   a_clearOnRead: assert property (p_clearOnRead) else $error("flags not cleared by report read");

   property p_dataHold;
      ce && !readPend_q |=> ((flagsQ & $past(flagsQ)) & ipi_pkg::DATA_FLAGS)
                            == ($past(flagsQ) & ipi_pkg::DATA_FLAGS);
   endproperty
   a_dataHold: assert property (p_dataHold) else $error("data flag cleared without sample read");

   property p_ptrStep;
      ce && !startSeen && !stopSeen && (wrStrobe || loadTx)
      |=> ptr_q == 8'($past(ptr_q) + 8'h01);
   endproperty
   a_ptrStep: assert property (p_ptrStep) else $error("pointer did not advance by one");
endmodule : ipi_top

// ==== hw/ipi_pkg.sv ====
// Constants, types and behaviour summary of the port and interrupt logic
// How it works
// - A write is START, address with write bit, register address, data bytes, STOP; each byte gets an ACK.
// - A read sets the pointer by a write, restarts, sends the read address, ACKs all but the last byte, then NACK and STOP.
// - The device drives the data line only in its ACK slots and while returning read bytes.
// - Two interrupt outputs, each driven to both levels.
// - Interrupt outputs are active high after reset; the invert bit of format_config makes them active low.
// - A function raises its flag only when enabled in irq_enable_mask; irq_pin_select routes it to output A or B.
// - Flags are latched; a data flag clears only when sample reads leave its condition false.
// - Reading irq_flag_report clears every latched flag except the data flags.
// - All functions work at once, and several may share one output.
// - Every function that can be enabled shows as a readable flag in irq_flag_report.
// - The bus address is 0x1D with addr_select_pin high and 0x53 with it low.
// - The new-sample flag is set while fresh data exists and clears when none remains.
package ipi_pkg;
   localparam logic [7:0] REG_ENABLE = 8'h2E;
   localparam logic [7:0] REG_PINSEL = 8'h2F;
   localparam logic [7:0] REG_FLAGS = 8'h30;
   localparam logic [7:0] REG_FORMAT = 8'h31;
   localparam logic [7:0] REG_SAMPLE_LO = 8'h32;
   localparam logic [7:0] REG_SAMPLE_HI = 8'h37;
   localparam logic [6:0] ADDR_PIN_HIGH = 7'h1D;
   localparam logic [6:0] ADDR_PIN_LOW = 7'h53;
   localparam logic [7:0] RST_ENABLE = 8'h00;
   localparam logic [7:0] RST_PINSEL = 8'h00;
   localparam logic [7:0] RST_FORMAT = 8'h00;
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam int FMT_INVERT_BIT = 5;
   // Flag bits: 7 new sample, 6..2 event functions, 1 watermark, 0 overrun
   localparam logic [7:0] DATA_FLAGS = 8'h83;
   localparam logic [7:0] OTHER_FLAGS = 8'h7C;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam int FLAG_W = 8;
   localparam int SAMPLE_W = 48;
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} ipi_state_e;
   typedef enum logic [1:0] {PH_ADDR, PH_REG, PH_DATA} ipi_phase_e;
endpackage : ipi_pkg

// ==== hw/ipi_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module ipi_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] q_d;

   if (W < 1) begin : g_chk
      $error("ipi_sync: width must be at least 1");
   end

   always_comb begin
      meta_d = d;
      q_d = meta_q;
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end else if (ce) begin
         meta_q <= meta_d;
         q <= q_d;
      end
   end
endmodule : ipi_sync

// ==== hw/ipi_irq_pin.sv ====
// One push-pull interrupt output with polarity
`timescale 1ns/10ps
module ipi_irq_pin #(
   parameter int FW = ipi_pkg::FLAG_W
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [FW-1:0] active,
   input wire logic invert,
   output logic level
);
   logic level_d;

   if (FW < 1) begin : g_chk
      $error("ipi_irq_pin: flag width must be at least 1");
   end

   // Any routed flag asserts the pin
   always_comb begin
      level_d = (|active) ^ invert;
   end

   // Driven every cycle to both levels
   always_ff @(posedge clock) begin
      if (!nrst) begin
         level <= 1'b0;
      end else if (ce) begin
         level <= level_d;
      end
   end
endmodule : ipi_irq_pin

// ==== testbench/ipi_bus_master.sv ====
// Bit-level bus master model driving clock and data pins
`timescale 1ns/10ps
module ipi_bus_master (
   output logic scl,
   output logic sdaDrv,
   input wire logic sdaWire
);
   localparam int Q = 80;
   int conflicts = 0;
   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end
   // One bit slot; clock stands high between frames
   task automatic bitx(input logic b, input logic own, output logic s);
      #Q;
      sdaDrv = b;
      #Q;
      scl = 1'b1;
      #Q;
      s = sdaWire;
      if (own && b && !s) conflicts++;
      #Q;
      scl = 1'b0;
   endtask : bitx
   task automatic start();
      // Let the slave drop its acknowledge before the clock rises
      #Q;
      sdaDrv = 1'b1;
      #Q;
      scl = 1'b1;
      #Q;
      sdaDrv = 1'b0;
      #Q;
      scl = 1'b0;
   endtask : start
   task automatic stop();
      #Q;
      sdaDrv = 1'b0;
      #Q;
      scl = 1'b1;
      #Q;
      sdaDrv = 1'b1;
      #Q;
   endtask : stop
   task automatic wrByte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bitx(b[i], 1'b1, s);
      bitx(1'b1, 1'b0, s);
      ack = !s;
   endtask : wrByte
   task automatic rdByte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bitx(1'b1, 1'b0, b[i]);
      bitx(last, 1'b1, s);
   endtask : rdByte
endmodule : ipi_bus_master

// ==== testbench/tb_top.sv ====
// Self-checking bench for the bus port and interrupt logic
`timescale 1ns/10ps
module tb_top;
   logic clock, nrst, ce, scl, sdaDrv, sdaOut, sdaOe, addrSelectPin, strb, irqOutA, irqOutB;
   logic [7:0] funcCond;
   logic [47:0] sampleData;
   logic [6:0] devAddr;
   logic [7:0] q[$];
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;
   int strobes = 0;
   wire sdaWire = sdaDrv & ~sdaOe;
   localparam logic [7:0] ROWS [6][3] = '{'{8'h2F, 8'hA5, 8'hA5}, '{8'h31, 8'h1F, 8'h1F},
      '{8'h2E, 8'h00, 8'h00}, '{8'h30, 8'hFF, 8'h00}, '{8'h10, 8'h55, 8'h00},
      '{8'h32, 8'h00, 8'hF6}};
   ipi_top u_dut (.clock(clock), .nrst(nrst), .ce(ce), .scl(scl), .sdaIn(sdaWire),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelectPin(addrSelectPin), .funcCond(funcCond),
      .sampleData(sampleData), .sampleReadStrobe(strb), .irqOutA(irqOutA), .irqOutB(irqOutB));
   ipi_bus_master u_mst (.scl(scl), .sdaDrv(sdaDrv), .sdaWire(sdaWire));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (strb === 1'b1) strobes++;
      if (cycles == 40000) begin
         n_errors++;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic regWrite(input logic [7:0] ra, input logic [7:0] d[$]);
      logic a;
      u_mst.start();
      u_mst.wrByte({devAddr, 1'b0}, a);
      chk("addr ack", 8'h01, {7'h00, a});
      u_mst.wrByte(ra, a);
      chk("reg ack", 8'h01, {7'h00, a});
      foreach (d[i]) begin
         u_mst.wrByte(d[i], a);
         chk("data ack", 8'h01, {7'h00, a});
      end
      u_mst.stop();
   endtask : regWrite
   task automatic regRead(input logic [7:0] ra, input int n);
      logic a;
      logic [7:0] b;
      q = {};
      u_mst.start();
      u_mst.wrByte({devAddr, 1'b0}, a);
      u_mst.wrByte(ra, a);
      u_mst.start();
      u_mst.wrByte({devAddr, 1'b1}, a);
      chk("read addr ack", 8'h01, {7'h00, a});
      for (int i = 0; i < n; i++) begin
         u_mst.rdByte(i == n - 1, b);
         q.push_back(b);
      end
      u_mst.stop();
      repeat (4) @(negedge clock);
   endtask : regRead
   task automatic pulse(input logic [7:0] v);
      @(posedge clock);
      funcCond <= v;
      @(posedge clock);
      funcCond <= 8'h00;
      repeat (4) @(negedge clock);
   endtask : pulse
   task automatic pins(input logic a, input logic b);
      chk("irqOutA", {7'h00, a}, {7'h00, irqOutA});
      chk("irqOutB", {7'h00, b}, {7'h00, irqOutB});
   endtask : pins
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run
   initial begin
      logic a;
      nrst = 1'b0;
      ce = 1'b1;
      addrSelectPin = 1'b1;
      funcCond = 8'h00;
      sampleData = 48'hA1B2C3D4E5F6;
      devAddr = ipi_pkg::ADDR_PIN_HIGH;
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      repeat (4) @(negedge clock);
      regRead(8'h2E, 4);
      foreach (q[i]) chk("reset value", 8'h00, q[i]);
      pins(1'b0, 1'b0);
      $display("test reset done");
      foreach (ROWS[r]) begin
         regWrite(ROWS[r][0], {ROWS[r][1]});
         regRead(ROWS[r][0], 1);
         chk("readback", ROWS[r][2], q[0]);
      end
      $display("test register rows done");
      regWrite(8'h2F, {8'h04});
      regWrite(8'h31, {8'h00});
      regWrite(8'h2E, {8'h44});
      pulse(8'h20);
      pins(1'b0, 1'b0);
      pulse(8'h40);
      pins(1'b1, 1'b0);
      pulse(8'h04);
      pins(1'b1, 1'b1);
      regRead(8'h30, 1);
      chk("flag report", 8'h44, q[0]);
      pins(1'b0, 1'b0);
      regWrite(8'h31, {8'h20});
      pins(1'b1, 1'b1);
      pulse(8'h40);
      pins(1'b0, 1'b1);
      regRead(8'h30, 1);
      $display("test event flags done");
      regWrite(8'h2E, {8'h80, 8'h00, 8'h00, 8'h00});
      @(posedge clock);
      funcCond <= 8'h80;
      repeat (4) @(negedge clock);
      pins(1'b1, 1'b0);
      regRead(8'h30, 1);
      chk("data flag report", 8'h80, q[0]);
      pins(1'b1, 1'b0);
      @(posedge clock);
      funcCond <= 8'h00;
      repeat (4) @(negedge clock);
      pins(1'b1, 1'b0);
      strobes = 0;
      regRead(8'h32, 2);
      chk("sample lo", 8'hF6, q[0]);
      chk("sample next", 8'hE5, q[1]);
      chk("strobes", 8'h02, strobes[7:0]);
      pins(1'b0, 1'b0);
      // Condition pulse while frozen must leave no latched flag
      @(posedge clock);
      ce <= 1'b0;
      pulse(8'h80);
      @(posedge clock);
      ce <= 1'b1;
      repeat (4) @(negedge clock);
      pins(1'b0, 1'b0);
      $display("test data flag done");
      devAddr = ipi_pkg::ADDR_PIN_LOW;
      u_mst.start();
      u_mst.wrByte({devAddr, 1'b0}, a);
      u_mst.stop();
      chk("foreign addr ack", 8'h00, {7'h00, a});
      @(posedge clock);
      addrSelectPin <= 1'b0;
      repeat (4) @(negedge clock);
      regRead(8'h2F, 1);
      chk("alt addr read", 8'h00, q[0]);
      chk("bus conflicts", 8'h00, u_mst.conflicts[7:0]);
      chk("sdaOut", 8'h00, {7'h00, sdaOut});
      $display("test address and bus done");
      complete_run();
   end
endmodule : tb_top
